// >>> rtl/bls_startup_sequencer.sv
// Operation
// RULE1: run while enable high, else shut down
// RULE2: stay disabled until supply lockout clears
// RULE3: timers count a 10 MHz tick; the minimum on-time counter (onCnt) counts 125 MHz clocks instead
// RULE4: three-bit field in 01h picks frequency
// RULE5: first sink disconnect gate to close switch
// RULE6: wait 500 us before output short check
// RULE7: output below 1.2 V disables, no boost
// RULE8: open and over-voltage must pass, then soft start
// RULE9: any input arrival order still starts properly
// RULE10: host should apply supply, dimming, then enable
// RULE11: register dimming ignores the dimming pin
// RULE12: low-side switch turns on each period start
// RULE13: low-side stays on at least 100 ns
// RULE14: comparator trip turns the low-side switch off
// RULE15: lowest active channel voltage is the feedback
// RULE16: gate held low while no fault present
// RULE17: unconnected address pins read as high
// RULE18: board grounds unused channel pins
// RULE19: board ties unused dimming pin high
// RULE20: grounded or disabled channels leave the loop
// RULE21: enable low or lockout returns to idle
// RULE22: status tells short from other failures
`timescale 1ns/10ps
module bls_startup_sequencer
    import bls_pkg::*;
#(
    parameter int SHORT_DELAY = SHORT_DELAY_TICKS
)
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // supply and enable
    input wire logic chipEnable,
    input wire logic supplyOk,
    // comparator levels
    input wire logic outBelowShort,
    input wire logic ledOpenFault,
    input wire logic overVoltFault,
    input wire logic senseTrip,
    // led channels
    input wire logic [NCH-1:0] ledPinGrounded,
    input wire logic [NCH-1:0] channel_enable_bits,
    input wire logic [NCH*FB_W-1:0] led_channel_pin,
    // dimming
    input wire logic dimmingPin,
    input wire logic dimFromRegister,
    // address pins
    input wire logic address_select_low,
    input wire logic addrLowFloating,
    input wire logic address_select_high,
    input wire logic addrHighFloating,
    // register port
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    // disconnect gate, open drain
    output logic input_disconnect_gate,
    output logic disconnectGateOe,
    // power stage
    output logic lowSideOn,
    output logic boosting,
    output logic [7:0] softStartLevel,
    // feedback selection
    output logic [NCH-1:0] activeChannels,
    output logic [2:0] feedbackChannel,
    output logic [FB_W-1:0] feedbackLevel,
    output logic feedbackValid,
    // misc status
    output logic dimmingActive,
    output logic [1:0] addressSelect,
    output logic shortFail,
    output logic protectFail
);
    bls_state_t state, next_state;
    logic [DLY_W-1:0] dlyCnt, next_dlyCnt;
    logic [7:0] next_softStartLevel;
    logic [NCH-1:0] next_activeChannels;
    logic next_shortFail;
    logic next_protectFail;
    logic [7:0] freqCfg, next_freqCfg;
    logic [7:0] next_regRdata;
    logic next_lowSideOn;
    logic [ON_W-1:0] onCnt, next_onCnt;
    logic [2:0] next_feedbackChannel;
    logic [FB_W-1:0] next_feedbackLevel;
    logic next_feedbackValid;
    logic next_dimmingActive;
    logic [1:0] next_addressSelect;
    logic tick10m;
    logic periodStart;
    logic switchRun;
    logic powerGood;

    assign powerGood = chipEnable && supplyOk; // [RULE1] [RULE2]
    assign switchRun = (state == S_SOFT) || (state == S_RUN);

    // tick and period timer
    bls_cycle_timer u_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(switchRun),
        .switch_freq_select(freqCfg[FS_MSB:FS_LSB]), // [RULE4]
        .tick10m(tick10m),
        .periodStart(periodStart)
    );

    // states read present levels only, so
    // supply, dimming and enable may come in any order
    always_comb begin
        next_state = state;
        next_dlyCnt = dlyCnt;
        next_softStartLevel = softStartLevel;
        next_activeChannels = activeChannels;
        next_shortFail = shortFail;
        next_protectFail = protectFail;
        if (!powerGood) begin
            next_state = S_IDLE; // [RULE21] [RULE9]
            next_softStartLevel = 8'h00;
            next_dlyCnt = '0;
        end else begin
            case (state)
                S_IDLE: begin
                    next_state = S_GATE;
                    next_shortFail = 1'b0;
                    next_protectFail = 1'b0;
                end
                S_GATE: begin
                    // gate sinks from here
                    next_state = S_WAIT; // [RULE5]
                    next_dlyCnt = DLY_W'(SHORT_DELAY);
                end
                S_WAIT: begin
                    if (tick10m) begin // [RULE3]
                        if (dlyCnt <= DLY_W'(1)) begin
                            next_state = S_SHORT; // [RULE6]
                        end
                        next_dlyCnt = dlyCnt - DLY_W'(1);
                    end
                end
                S_SHORT: begin
                    if (outBelowShort) begin
                        next_state = S_FAULT; // [RULE7]
                        next_shortFail = 1'b1; // [RULE22]
                    end else begin
                        next_state = S_SAFE;
                    end
                end
                S_SAFE: begin
                    // unused strings leave the loop
                    next_activeChannels =
                        channel_enable_bits & ~ledPinGrounded; // [RULE20]
                    if (ledOpenFault || overVoltFault ||
                        (next_activeChannels == '0)) begin
                        next_state = S_FAULT; // [RULE8]
                        next_protectFail = 1'b1; // [RULE22]
                    end else begin
                        next_state = S_SOFT; // [RULE8]
                        next_softStartLevel = 8'h00;
                        next_dlyCnt = DLY_W'(SOFT_STEP_TICKS);
                    end
                end
                S_SOFT: begin
                    // soft start ramps on ticks
                    if (tick10m) begin
                        if (dlyCnt <= DLY_W'(1)) begin
                            next_dlyCnt = DLY_W'(SOFT_STEP_TICKS);
                            if (softStartLevel == 8'hff) begin
                                next_state = S_RUN;
                            end else begin
                                next_softStartLevel =
                                    softStartLevel + 8'h01;
                            end
                        end else begin
                            next_dlyCnt = dlyCnt - DLY_W'(1);
                        end
                    end
                end
                S_RUN: begin
                    next_state = S_RUN;
                end
                S_FAULT: begin
                    // latched until enable or supply drops
                    next_state = S_FAULT;
                end
                default: begin
                    next_state = S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= S_IDLE;
            dlyCnt <= '0;
            softStartLevel <= 8'h00;
            activeChannels <= '0;
            shortFail <= 1'b0;
            protectFail <= 1'b0;
        end else begin
            state <= next_state;
            dlyCnt <= next_dlyCnt;
            softStartLevel <= next_softStartLevel;
            activeChannels <= next_activeChannels;
            shortFail <= next_shortFail;
            protectFail <= next_protectFail;
        end
    end

    // gate sinks from first step until fault or shutdown
    assign input_disconnect_gate = 1'b0;
    assign disconnectGateOe = (state != S_IDLE) &&
        (state != S_FAULT); // [RULE5] [RULE16] [RULE21]
    assign boosting = switchRun;

    // low side: on each period, off on trip past min on
    always_comb begin
        next_lowSideOn = lowSideOn;
        next_onCnt = onCnt;
        if (!switchRun) begin
            next_lowSideOn = 1'b0; // [RULE21]
            next_onCnt = '0;
        end else if (periodStart) begin
            next_lowSideOn = 1'b1; // [RULE12]
            next_onCnt = '0;
        end else if (lowSideOn) begin
            if (onCnt < ON_W'(MIN_ON_CYCLES)) begin
                next_onCnt = onCnt + ON_W'(1); // [RULE13]
            end else if (senseTrip) begin
                next_lowSideOn = 1'b0; // [RULE14]
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lowSideOn <= 1'b0;
            onCnt <= '0;
        end else begin
            lowSideOn <= next_lowSideOn;
            onCnt <= next_onCnt;
        end
    end

    // lowest active channel, one compare per channel
    logic [FB_W-1:0] minVal [NCH:0];
    logic [2:0] minIdx [NCH:0];
    logic minHit [NCH:0];
    assign minVal[0] = '1;
    assign minIdx[0] = 3'h0;
    assign minHit[0] = 1'b0;
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_min
            logic [FB_W-1:0] v;
            logic take;
            assign v = led_channel_pin[g*FB_W +: FB_W];
            assign take = activeChannels[g] &&
                (!minHit[g] || (v < minVal[g])); // [RULE15]
            assign minVal[g+1] = take ? v : minVal[g];
            assign minIdx[g+1] = take ? 3'(g) : minIdx[g];
            assign minHit[g+1] = minHit[g] || activeChannels[g];
        end
    endgenerate

    // registered feedback and pin picks
    always_comb begin
        next_feedbackChannel = minIdx[NCH];
        next_feedbackLevel = minVal[NCH];
        next_feedbackValid = minHit[NCH] && switchRun;
        // register dimming ignores the pin
        next_dimmingActive = dimFromRegister || dimmingPin; // [RULE11]
        // a floating pin reads high via the pull-up
        next_addressSelect[0] = addrLowFloating ||
            address_select_low; // [RULE17]
        next_addressSelect[1] = addrHighFloating ||
            address_select_high; // [RULE17]
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            feedbackChannel <= 3'h0;
            feedbackLevel <= '0;
            feedbackValid <= 1'b0;
            dimmingActive <= 1'b0;
            addressSelect <= 2'h3;
        end else begin
            feedbackChannel <= next_feedbackChannel;
            feedbackLevel <= next_feedbackLevel;
            feedbackValid <= next_feedbackValid;
            dimmingActive <= next_dimmingActive;
            addressSelect <= next_addressSelect;
        end
    end

    // frequency config writable, status read-only;
    // new frequency applies at the next period reload
    always_comb begin
        next_freqCfg = freqCfg;
        next_regRdata = regRdata;
        if (regWrite && (regAddr == REG_FREQ_CFG)) begin
            next_freqCfg = regWdata; // [RULE4]
        end
        if (regRead) begin
            case (regAddr)
                REG_FREQ_CFG: next_regRdata = freqCfg;
                REG_STATUS: begin
                    next_regRdata = 8'h00;
                    next_regRdata[ST_SHORT] = shortFail; // [RULE22]
                    next_regRdata[ST_PROT] = protectFail; // [RULE22]
                    next_regRdata[ST_BOOST] = switchRun;
                    next_regRdata[ST_GATE] = disconnectGateOe;
                end
                default: next_regRdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            freqCfg <= FREQ_CFG_RESET;
            regRdata <= 8'h00;
        end else begin
            freqCfg <= next_freqCfg;
            regRdata <= next_regRdata;
        end
    end
endmodule : bls_startup_sequencer

// >>> rtl/bls_pkg.sv
package bls_pkg;
    // clock rates in kHz; the accumulator must hold wrap plus step
    localparam int CLK_KHZ = 125000;
    localparam int TIMER_KHZ = 10000;
    localparam int ACC_W = 18;
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(TIMER_KHZ);
    localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_KHZ);

    // timing figures and derived counts
    localparam int CLK_PERIOD_NS = 8;
    localparam int MIN_ON_NS = 100;
    localparam int MIN_ON_CYCLES =
        (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SHORT_DELAY_US = 500;
    localparam int SHORT_DELAY_TICKS = SHORT_DELAY_US * TIMER_KHZ / 1000;
    localparam int SOFT_STEP_TICKS = 4;
    localparam int DLY_W = 16;
    localparam int ON_W = 5;
    localparam int PER_W = 6;

    // register map
    localparam logic [7:0] REG_FREQ_CFG = 8'h01;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] FREQ_CFG_RESET = 8'h00;
    localparam int FS_LSB = 0;
    localparam int FS_MSB = 2;
    localparam int ST_SHORT = 0;
    localparam int ST_PROT = 1;
    localparam int ST_BOOST = 2;
    localparam int ST_GATE = 3;

    localparam int NCH = 8;
    localparam int FB_W = 8;

    // one-hot sequencer states
    typedef enum logic [7:0] {
        S_IDLE = 8'h01,
        S_GATE = 8'h02,
        S_WAIT = 8'h04,
        S_SHORT = 8'h08,
        S_SAFE = 8'h10,
        S_SOFT = 8'h20,
        S_RUN = 8'h40,
        S_FAULT = 8'h80
    } bls_state_t;

    // switching period in ticks per frequency code
    // 350k,500k,650k,800k,950k,1.2M,1.8M,2.4M; coarse at high rates
    function automatic logic [PER_W-1:0] bls_period_ticks(
        input logic [2:0] sel
    );
        case (sel)
            3'h0: bls_period_ticks = 6'h1c;
            3'h1: bls_period_ticks = 6'h14;
            3'h2: bls_period_ticks = 6'h0f;
            3'h3: bls_period_ticks = 6'h0c;
            3'h4: bls_period_ticks = 6'h0a;
            3'h5: bls_period_ticks = 6'h08;
            3'h6: bls_period_ticks = 6'h05;
            default: bls_period_ticks = 6'h04;
        endcase
    endfunction : bls_period_ticks
endpackage : bls_pkg

// >>> rtl/bls_cycle_timer.sv
`timescale 1ns/10ps
module bls_cycle_timer
    import bls_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // control
    input wire logic run,
    input wire logic [2:0] switch_freq_select,
    // timing outputs
    output logic tick10m,
    output logic periodStart
);
    logic [ACC_W-1:0] acc, next_acc;
    logic next_tick;
    logic [PER_W-1:0] perCnt, next_perCnt;
    logic next_periodStart;
    logic [ACC_W-1:0] sum;

    // fractional divider: 125 MHz has no integer ratio to 10 MHz
    always_comb begin
        sum = acc + ACC_STEP;
        if (sum >= ACC_WRAP) begin
            next_acc = sum - ACC_WRAP;
            next_tick = 1'b1;
        end else begin
            next_acc = sum;
            next_tick = 1'b0;
        end
    end

    // period counter steps on the timer tick only
    always_comb begin
        next_perCnt = perCnt;
        next_periodStart = 1'b0;
        if (!run) begin
            next_perCnt = '0;
        end else if (tick10m) begin
            if (perCnt == '0) begin
                next_periodStart = 1'b1;
                next_perCnt = bls_period_ticks(switch_freq_select)
                    - PER_W'(1);
            end else begin
                next_perCnt = perCnt - PER_W'(1);
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc <= '0;
            tick10m <= 1'b0;
            perCnt <= '0;
            periodStart <= 1'b0;
        end else begin
            acc <= next_acc;
            tick10m <= next_tick;
            perCnt <= next_perCnt;
            periodStart <= next_periodStart;
        end
    end
endmodule : bls_cycle_timer

// >>> testbench/bls_startup_sequencer_props.sv
`timescale 1ns/10ps
module bls_startup_props
    import bls_pkg::*;
#(
    parameter int SHORT_DELAY = SHORT_DELAY_TICKS
)
(
    // clock and reset
    input logic clk,
    input logic sys_rst,
    // watched inputs
    input logic chipEnable,
    input logic supplyOk,
    input logic senseTrip,
    input logic [NCH*FB_W-1:0] led_channel_pin,
    input logic address_select_low,
    input logic addrLowFloating,
    // watched outputs
    input logic input_disconnect_gate,
    input logic disconnectGateOe,
    input logic lowSideOn,
    input logic boosting,
    input logic [NCH-1:0] activeChannels,
    input logic [FB_W-1:0] feedbackLevel,
    input logic feedbackValid,
    input logic [1:0] addressSelect,
    input logic shortFail,
    input logic protectFail
);
    // the tick lands every 12 or 13 clocks, so 12 is the safe floor
    localparam int MIN_WAIT = (SHORT_DELAY - 1) * 12;
    logic [19:0] gateCycles, next_gateCycles;
    logic [7:0] onCount, next_onCount;
    logic [FB_W-1:0] minLevel;

    // cycles of gate sink and of switch on
    always_comb begin
        next_gateCycles = disconnectGateOe ? gateCycles + 20'h1 : 20'h0;
        next_onCount = 8'h0;
        if (lowSideOn) begin
            next_onCount = (onCount == 8'hff) ? onCount : onCount + 8'h1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            gateCycles <= 20'h0;
            onCount <= 8'h0;
        end else begin
            gateCycles <= next_gateCycles;
            onCount <= next_onCount;
        end
    end

    // lowest active channel level
    always_comb begin
        minLevel = '1;
        for (int g = 0; g < NCH; g++) begin
            if (activeChannels[g] &&
                led_channel_pin[g*FB_W +: FB_W] < minLevel) begin
                minLevel = led_channel_pin[g*FB_W +: FB_W];
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence sEnableRise;
        chipEnable && supplyOk && !$past(chipEnable);
    endsequence
    sequence sMinOn;
        (lowSideOn || !boosting) [*8] ##1 (lowSideOn || !boosting) [*5];
    endsequence

    AST_OFF_IDLE: assert property (
        !(chipEnable && supplyOk) |=> !disconnectGateOe && !boosting
    ) else $error("not idle when off");
    AST_GATE_FIRST: assert property (
        sEnableRise |=> disconnectGateOe && !boosting
    ) else $error("gate not sunk first");
    AST_SHORT_WAIT: assert property (
        $rose(shortFail) || $rose(boosting) |-> gateCycles >= MIN_WAIT
    ) else $error("short check came early");
    AST_SHORT_STOP: assert property (
        shortFail |-> !boosting && !lowSideOn
    ) else $error("boosting despite short");
    AST_BOOST_GUARD: assert property (
        $rose(boosting) |-> !shortFail && !protectFail && activeChannels != 0
    ) else $error("boost without checks");
    AST_GATE_HELD: assert property (
        boosting |-> disconnectGateOe && !input_disconnect_gate
    ) else $error("gate released while running");
    AST_LS_IDLE: assert property (
        !boosting && !$past(boosting) |-> !lowSideOn
    ) else $error("switch on while not boosting");
    AST_MIN_ON: assert property (
        $rose(lowSideOn) |-> sMinOn
    ) else $error("on time below minimum");
    AST_TRIP_OFF: assert property (
        lowSideOn && senseTrip && onCount >= 8'h10 |-> ##[1:2] !lowSideOn
    ) else $error("trip ignored");
    AST_FB_MIN: assert property (
        feedbackValid && $stable(led_channel_pin) && $stable(activeChannels)
            |-> feedbackLevel == minLevel
    ) else $error("feedback not lowest channel");
    AST_ADDR_PULLUP: assert property (
        1'b1 |=> addressSelect[0] == $past(address_select_low | addrLowFloating)
    ) else $error("address pin level wrong");
endmodule : bls_startup_props

bind bls_startup_sequencer bls_startup_props #(
    .SHORT_DELAY(SHORT_DELAY)
) props (.*);

// >>> testbench/bls_stage_model.sv
`timescale 1ns/10ps
module bls_stage_model (
    // clock
    input logic clk,
    // device side
    input logic input_disconnect_gate,
    input logic disconnectGateOe,
    input logic lowSideOn,
    // scenario controls
    input logic outShorted,
    input logic openLed,
    input logic overVolt,
    input logic [7:0] tripAfter,
    // sensed results
    output logic outBelowShort,
    output logic ledOpenFault,
    output logic overVoltFault,
    output logic senseTrip
);
    logic gateLevel;
    logic [7:0] ramp, next_ramp;

    // the gate has a pull-up to the input rail, so released means open
    assign gateLevel = disconnectGateOe ? input_disconnect_gate : 1'b1;
    // output stays near ground until the switch closes
    assign outBelowShort = outShorted | gateLevel;
    assign ledOpenFault = openLed;
    assign overVoltFault = overVolt;
    // inductor current ramps only while the switch conducts
    always_comb begin
        next_ramp = lowSideOn ? ramp + 8'h1 : 8'h0;
    end
    always_ff @(posedge clk) begin
        ramp <= next_ramp;
    end
    assign senseTrip = lowSideOn && ramp >= tripAfter;
endmodule : bls_stage_model

// >>> testbench/boost_led_startup_sequencer_tb.sv
`timescale 1ns/10ps
module boost_led_startup_sequencer_tb;
    import bls_pkg::*;
    localparam int SD = 20;
    // period in ticks per frequency code
    localparam int PER [0:7] = '{28, 20, 15, 12, 10, 8, 5, 4};
    logic clk = 1'b0, sys_rst = 1'b1, chipEnable = 1'b0, supplyOk = 1'b0;
    logic outShorted = 1'b0, openLed = 1'b0, overVolt = 1'b0;
    logic [7:0] tripAfter = 8'h1e;
    logic outBelowShort, ledOpenFault, overVoltFault, senseTrip;
    logic [NCH-1:0] ledPinGrounded = 8'h01; // channel 0 grounded
    logic [NCH-1:0] channel_enable_bits = 8'hfd;
    logic [NCH*FB_W-1:0] led_channel_pin = 64'h6464_2864_6464_0a00;
    logic dimmingPin = 1'b1; // unused input held high
    logic address_select_low = 1'b0, addrLowFloating = 1'b1;
    logic address_select_high = 1'b0, addrHighFloating = 1'b1;
    logic regWrite = 1'b0, regRead = 1'b0, dimFromRegister = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic [7:0] regRdata, softStartLevel, feedbackLevel;
    logic input_disconnect_gate, disconnectGateOe, lowSideOn, boosting;
    logic [NCH-1:0] activeChannels;
    logic [2:0] feedbackChannel;
    logic feedbackValid, dimmingActive, shortFail, protectFail;
    logic [1:0] addressSelect;
    int mismatches = 0, checks_done = 0;

    bls_startup_sequencer #(.SHORT_DELAY(SD)) uut (.*);
    bls_stage_model model (.*);

    always #4 clk = ~clk;

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chkByte(input string what, input logic [7:0] e,
        input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
            mismatches++;
        end
    endtask : chkByte

    task automatic chkBit(input string what, input logic e, input logic g);
        chkByte(what, {7'h0, e}, {7'h0, g});
    endtask : chkBit

    task automatic regWr(input logic [7:0] a, input logic [7:0] d);
        regWrite = 1'b1;
        regAddr = a;
        regWdata = d;
        cyc(1);
        regWrite = 1'b0;
    endtask : regWr

    task automatic regChk(input logic [7:0] a, input logic [7:0] e);
        regRead = 1'b1;
        regAddr = a;
        cyc(1);
        regRead = 1'b0;
        chkByte("register", e, regRdata);
    endtask : regChk

    // sel: 0 boosting, 1 short, 2 protect
    task automatic waitHigh(input int sel);
        logic seen = 1'b0;
        int n = 0;
        while (!seen && n < 20000) begin
            cyc(1);
            n++;
            seen = sel == 0 ? boosting === 1'b1 :
                sel == 1 ? shortFail === 1'b1 : protectFail === 1'b1;
        end
        if (!seen) begin
            $display("CHECK FAILED wait %0d expected 1 seen 0", sel);
            mismatches++;
            tally_and_finish();
        end
        chkBit("delay", 1'b1, n >= (SD-1)*12 && n <= SD*13+8);
    endtask : waitHigh

    task automatic waitLevel(input logic v, inout int n);
        while (lowSideOn !== v && n < 2000) begin
            cyc(1);
            n++;
        end
        if (n >= 2000) begin
            $display("CHECK FAILED switch expected %b seen %b", v, lowSideOn);
            mismatches++;
            tally_and_finish();
        end
    endtask : waitLevel

    task automatic measure(output int per, output int onw);
        int n;
        n = 0;
        // skip one period: its reload may predate a new code
        waitLevel(1'b0, n);
        waitLevel(1'b1, n);
        waitLevel(1'b0, n);
        waitLevel(1'b1, n);
        n = 0;
        waitLevel(1'b0, n);
        onw = n;
        waitLevel(1'b1, n);
        per = n;
    endtask : measure

    task automatic scnReset();
        chkByte("addr", 8'h03, {6'h0, addressSelect});
        chkBit("gate", 1'b0, disconnectGateOe);
        regChk(REG_FREQ_CFG, FREQ_CFG_RESET);
        regWr(REG_FREQ_CFG, 8'ha5);
        regChk(REG_FREQ_CFG, 8'ha5);
        regWr(8'h22, 8'h5a);
        regChk(8'h22, 8'h00);
        regChk(REG_FREQ_CFG, 8'ha5);
        regWr(REG_FREQ_CFG, 8'h00);
    endtask : scnReset

    task automatic scnStart(input logic supplyLast);
        if (supplyLast) begin
            chipEnable = 1'b1;
            cyc(4);
            chkBit("gate", 1'b0, disconnectGateOe);
            supplyOk = 1'b1;
        end else begin
            supplyOk = 1'b1; // supply before enable
            cyc(4);
            chipEnable = 1'b1;
        end
        cyc(1);
        chkBit("gate", 1'b1, disconnectGateOe);
        waitHigh(0);
        chkByte("soft", 8'h00, softStartLevel);
        chkBit("pin", 1'b0, input_disconnect_gate);
        regChk(REG_STATUS, 8'h0c);
        cyc(2);
        chkBit("valid", 1'b1, feedbackValid);
        chkByte("active", 8'hfc, activeChannels);
        chkByte("level", 8'h28, feedbackLevel);
        chkByte("chan", 8'h05, {5'h0, feedbackChannel});
    endtask : scnStart

    task automatic scnFreq();
        int per, onw, e;
        for (int c = 0; c < 8; c++) begin
            regWr(REG_FREQ_CFG, 8'(c));
            measure(per, onw);
            e = PER[c] * 125 / 10;
            chkBit("period", 1'b1, per >= e-13 && per <= e+13);
            chkBit("on", 1'b1, onw >= 30 && onw <= 33);
        end
        tripAfter = 8'h02;
        regWr(REG_FREQ_CFG, 8'h00);
        measure(per, onw);
        chkBit("min on", 1'b1, onw >= 13 && onw <= 16);
        tripAfter = 8'h1e;
    endtask : scnFreq

    task automatic scnStop(input logic viaSupply);
        if (viaSupply) supplyOk = 1'b0;
        else chipEnable = 1'b0;
        cyc(1);
        chkBit("gate", 1'b0, disconnectGateOe);
        chkBit("boost", 1'b0, boosting);
        cyc(1);
        chkBit("switch", 1'b0, lowSideOn);
        chipEnable = 1'b0;
        supplyOk = 1'b1;
        cyc(2);
    endtask : scnStop

    // fault knobs and channel enables; expect status code
    task automatic scnFault(input logic sh, input logic op,
        input logic ov, input logic [7:0] chen, input logic [7:0] st);
        outShorted = sh;
        openLed = op;
        overVolt = ov;
        channel_enable_bits = chen;
        chipEnable = 1'b1;
        waitHigh(sh ? 1 : 2);
        cyc(2);
        chkBit("boost", 1'b0, boosting);
        regChk(REG_STATUS, st);
        chipEnable = 1'b0;
        cyc(2);
    endtask : scnFault

    task automatic scnPins();
        for (int i = 0; i < 4; i++) begin
            addrLowFloating = i[1];
            address_select_low = i[0];
            addrHighFloating = i[0];
            address_select_high = i[1];
            dimFromRegister = i[1];
            dimmingPin = i[0];
            cyc(2);
            chkByte("addr", {6'h0, {2{|i[1:0]}}},
                {6'h0, addressSelect});
            chkBit("dim", i[1] | i[0], dimmingActive);
        end
        dimmingPin = 1'b1;
    endtask : scnPins

    initial begin
        cyc(2);
        sys_rst = 1'b0;
        scnReset();
        scnStart(1'b1);
        scnFreq();
        scnStop(1'b0);
        scnStart(1'b0);
        scnStop(1'b1);
        scnFault(1'b1, 1'b0, 1'b0, 8'hfd, 8'h01);
        scnFault(1'b0, 1'b1, 1'b0, 8'hfd, 8'h02);
        scnFault(1'b0, 1'b0, 1'b1, 8'hfd, 8'h02);
        scnFault(1'b0, 1'b0, 1'b0, 8'h00, 8'h02);
        scnPins();
        tally_and_finish();
    end
endmodule : boost_led_startup_sequencer_tb
